// ### core/tpc_pkg.sv
// Shared constants of the timer pin control block: register map, field
// layout, reset values and the codes of the two-bit action field.
// Assumes a 32-bit classic Wishbone bus with byte addresses.
package tpc_pkg;
    // Register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_CHA_IO = 8'h04;
    localparam logic [7:0] OFS_CD_IO = 8'h08;
    localparam logic [7:0] OFS_COUNT = 8'h0C;
    localparam logic [7:0] OFS_GR_A = 8'h10;
    localparam logic [7:0] OFS_GR_C = 8'h14;
    localparam logic [7:0] OFS_GR_D = 8'h18;
    localparam logic [7:0] OFS_STATUS = 8'h1C;
    localparam logic [7:0] OFS_MASK = 8'h20;
    localparam logic [7:0] OFS_PINS = 8'h24;
    // Channel slots
    localparam int NCH = 3;
    localparam int CH_A = 0;
    localparam int CH_C = 1;
    localparam int CH_D = 2;
    // Field positions
    localparam int CTRL_RUN_BIT = 0;
    localparam int ROLE_BIT = 2;
    localparam int CD_D_LSB = 4;
    localparam int CD_RSVD_BIT = 7;
    // Reset values
    localparam logic [15:0] CNT_RESET = 16'h0000;
    localparam logic [15:0] GR_RESET = 16'hFFFF;
    localparam logic [1:0] ACT_RESET = 2'h0;
    localparam logic CD_RSVD_VAL = 1'b1;
    // Role selector values
    localparam logic ROLE_COMPARE = 1'b0;
    localparam logic ROLE_CAPTURE = 1'b1;
    // Compare mode actions
    localparam logic [1:0] ACT_NONE = 2'h0;
    localparam logic [1:0] ACT_LOW = 2'h1;
    localparam logic [1:0] ACT_HIGH = 2'h2;
    localparam logic [1:0] ACT_TOGGLE = 2'h3;
    // Capture mode edges; bit 1 set means both edges
    localparam logic [1:0] EDGE_RISE = 2'h0;
    localparam logic [1:0] EDGE_FALL = 2'h1;
    localparam int EDGE_BOTH_BIT = 1;
endpackage

// ### core/tpc_chan_if.sv
// Carrier between the register core and one channel unit.
// Assumes one clock; all signals are sampled on CLK.
`timescale 1ns/10ps
`default_nettype none
interface tpc_chan_if;
    logic role;
    logic [1:0] action;
    logic [15:0] gr;
    logic [15:0] counter;
    logic tick;
    logic pin_in;
    logic pin_out;
    logic match;
    logic capture;
    // Core side
    modport ctl (output role, action, gr, counter, tick, pin_in,
                 input pin_out, match, capture);
    // Channel side
    modport unit (input role, action, gr, counter, tick, pin_in,
                  output pin_out, match, capture);
endinterface
`default_nettype wire

// ### core/tpc_channel.sv
// One compare/capture channel: pin action on compare match, edge detect
// for capture. Assumes the pin input is already synchronous to CLK.
`timescale 1ns/10ps
`default_nettype none
module tpc_channel
    import tpc_pkg::*;
(
    // Clock and reset
    input wire logic CLK,
    input wire logic RESET_N,
    // Link to the core
    tpc_chan_if.unit ch
);
    typedef struct packed {
        logic pin;
        logic prev;
    } tpc_chan_st_t;

    tpc_chan_st_t s_q, s_d;
    logic rise, fall, hit, cap;

    // Edge detect and compare; the match only fires on the counter step
    always_comb begin
        s_d = s_q;
        rise = ch.pin_in & ~s_q.prev;
        fall = ~ch.pin_in & s_q.prev;
        hit = ch.tick && (ch.counter == ch.gr) && (ch.role == ROLE_COMPARE);
        cap = 1'b0;
        s_d.prev = ch.pin_in;
        if (ch.role == ROLE_CAPTURE) begin
            if (ch.action[EDGE_BOTH_BIT]) begin
                cap = rise | fall;
            end else if (ch.action == EDGE_FALL) begin
                cap = fall;
            end else begin
                cap = rise;
            end
        end
        if (hit) begin
            case (ch.action)
                ACT_LOW: s_d.pin = 1'b0;
                ACT_HIGH: s_d.pin = 1'b1;
                ACT_TOGGLE: s_d.pin = ~s_q.pin;
                default: s_d.pin = s_q.pin;
            endcase
        end
    end

    // State register
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign ch.pin_out = s_q.pin;
    assign ch.match = hit;
    assign ch.capture = cap;
endmodule
`default_nettype wire

// ### core/tpc_irq.sv
// Sticky event flags with mask and one level interrupt.
// Assumes clr only names bits that software has already been shown.
`timescale 1ns/10ps
`default_nettype none
module tpc_irq #(
    parameter int N = 3
) (
    // Clock and reset
    input wire logic CLK,
    input wire logic RESET_N,
    // Events and control
    input wire logic [N-1:0] set,
    input wire logic [N-1:0] clr,
    input wire logic [N-1:0] mask,
    // Results
    output logic [N-1:0] status,
    output logic irq
);
    typedef struct packed {
        logic [N-1:0] flags;
    } tpc_irq_st_t;

    tpc_irq_st_t s_q, s_d;

    if (N < 1 || N > 16) begin : g_chk
        $error("tpc_irq: N must be 1 to 16");
    end

    // A set in the clearing cycle wins, so no event is lost
    always_comb begin
        s_d.flags = (s_q.flags & ~clr) | set;
    end

    // State register
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign status = s_q.flags;
    assign irq = |(s_q.flags & mask);
endmodule
`default_nettype wire

// ### core/tpc_top.sv
// Timer pin control: 16-bit up counter, three general registers used
// for output compare or input capture, and the pin control registers.
// Assumes a classic Wishbone master and pins synchronous to CLK.
//
// How it works
// - In compare mode the channel A code picks no change, drive low, drive high or toggle on match.
// - In capture mode the channel A code picks rising, falling, or both edges when bit 1 is set.
// - The channel A code lives in bits 1:0 of its control register, is read/write and resets to 0.
// - A second control register sets the role and pin behaviour of channels C and D.
// - Bit 7 of the channel C/D control register is reserved and always reads 1.
// - A per-channel role bit of 0 makes the general register compare, 1 makes it capture.
// - A compare match and its pin action happen only as the counter steps off the match value.
// - A capture edge stores the current counter in the general register and raises the flag.
//
// The register offsets and register access over Wishbone are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
module tpc_top
    import tpc_pkg::*;
(
    // Clock and reset
    input wire logic CLK,
    input wire logic RESET_N,
    // Wishbone slave
    input wire logic [7:0] WB_ADR_I,
    input wire logic [31:0] WB_DAT_I,
    input wire logic [3:0] WB_SEL_I,
    input wire logic WB_WE_I,
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    output logic [31:0] WB_DAT_O,
    output logic WB_ACK_O,
    // Channel pins
    input wire logic CHAN_A_PIN_I,
    output logic CHAN_A_PIN_O,
    output logic CHAN_A_PIN_OE,
    input wire logic CHAN_C_PIN_I,
    output logic CHAN_C_PIN_O,
    output logic CHAN_C_PIN_OE,
    input wire logic CHAN_D_PIN_I,
    output logic CHAN_D_PIN_O,
    output logic CHAN_D_PIN_OE,
    // Interrupt
    output logic IRQ_O
);
    typedef struct packed {
        logic run;
        logic [NCH-1:0] role;
        logic [NCH-1:0][1:0] act;
        logic [15:0] cnt;
        logic [NCH-1:0][15:0] gr;
        logic [NCH-1:0] mask;
        logic ack;
        logic [31:0] rdata;
    } tpc_top_st_t;

    tpc_top_st_t s_q, s_d;
    tpc_chan_if ch [NCH] ();
    logic [NCH-1:0] pin_in, pin_out, match, capture, status, clr;
    logic req, acc, wr, irq;
    logic [31:0] rd_mux;

    // Merge a 16-bit write under the two low byte enables
    function automatic logic [15:0] wr16(input logic [15:0] old,
                                         input logic [31:0] dat,
                                         input logic [3:0] sel);
        logic [15:0] r;
        r = old;
        if (sel[0]) begin
            r[7:0] = dat[7:0];
        end
        if (sel[1]) begin
            r[15:8] = dat[15:8];
        end
        return r;
    endfunction

    assign pin_in = {CHAN_D_PIN_I, CHAN_C_PIN_I, CHAN_A_PIN_I};

    // One channel unit per general register
    for (genvar i = 0; i < NCH; i++) begin : g_ch
        assign ch[i].role = s_q.role[i];
        assign ch[i].action = s_q.act[i];
        assign ch[i].gr = s_q.gr[i];
        assign ch[i].counter = s_q.cnt;
        assign ch[i].tick = s_q.run;
        assign ch[i].pin_in = pin_in[i];
        assign pin_out[i] = ch[i].pin_out;
        assign match[i] = ch[i].match;
        assign capture[i] = ch[i].capture;
        tpc_channel u_ch (
            .CLK(CLK),
            .RESET_N(RESET_N),
            .ch(ch[i])
        );
    end

    // Flags: compare match or capture, cleared by reading STATUS
    tpc_irq #(.N(NCH)) u_irq (
        .CLK(CLK),
        .RESET_N(RESET_N),
        .set(match | capture),
        .clr(clr),
        .mask(s_q.mask),
        .status(status),
        .irq(irq)
    );

    // Bus phases: acc is the first cycle, wr is the ack edge of a write
    assign req = WB_CYC_I & WB_STB_I;
    assign acc = req & ~s_q.ack;
    assign wr = req & s_q.ack & WB_WE_I;
    // Only the bits handed out in rdata are cleared, later events survive
    assign clr = (req & s_q.ack & ~WB_WE_I & (WB_ADR_I == OFS_STATUS))
        ? s_q.rdata[NCH-1:0] : '0;

    // Read multiplexer; unmapped addresses read as zero
    always_comb begin
        rd_mux = 32'h0000_0000;
        case (WB_ADR_I)
            OFS_CTRL: rd_mux[CTRL_RUN_BIT] = s_q.run;
            OFS_CHA_IO: rd_mux[2:0] = {s_q.role[CH_A], s_q.act[CH_A]};
            OFS_CD_IO: rd_mux[7:0] = {CD_RSVD_VAL, s_q.role[CH_D], s_q.act[CH_D],
                                      1'b0, s_q.role[CH_C], s_q.act[CH_C]};
            OFS_COUNT: rd_mux[15:0] = s_q.cnt;
            OFS_GR_A: rd_mux[15:0] = s_q.gr[CH_A];
            OFS_GR_C: rd_mux[15:0] = s_q.gr[CH_C];
            OFS_GR_D: rd_mux[15:0] = s_q.gr[CH_D];
            OFS_STATUS: rd_mux[NCH-1:0] = status;
            OFS_MASK: rd_mux[NCH-1:0] = s_q.mask;
            OFS_PINS: rd_mux[5:0] = {pin_in, pin_out};
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    // Next state: bus writes, counter step, captures
    always_comb begin
        s_d = s_q;
        s_d.ack = acc;
        if (acc) begin
            s_d.rdata = rd_mux;
        end
        if (s_q.run) begin
            s_d.cnt = s_q.cnt + 16'h0001;
        end
        if (wr) begin
            case (WB_ADR_I)
                OFS_CTRL: begin
                    if (WB_SEL_I[0]) begin
                        s_d.run = WB_DAT_I[CTRL_RUN_BIT];
                    end
                end
                OFS_CHA_IO: begin
                    if (WB_SEL_I[0]) begin
                        s_d.act[CH_A] = WB_DAT_I[1:0];
                        s_d.role[CH_A] = WB_DAT_I[ROLE_BIT];
                    end
                end
                OFS_CD_IO: begin
                    if (WB_SEL_I[0]) begin
                        s_d.act[CH_C] = WB_DAT_I[1:0];
                        s_d.role[CH_C] = WB_DAT_I[ROLE_BIT];
                        s_d.act[CH_D] = WB_DAT_I[CD_D_LSB +: 2];
                        s_d.role[CH_D] = WB_DAT_I[CD_D_LSB + ROLE_BIT];
                    end
                end
                OFS_COUNT: s_d.cnt = wr16(s_q.cnt, WB_DAT_I, WB_SEL_I);
                OFS_GR_A: s_d.gr[CH_A] = wr16(s_q.gr[CH_A], WB_DAT_I, WB_SEL_I);
                OFS_GR_C: s_d.gr[CH_C] = wr16(s_q.gr[CH_C], WB_DAT_I, WB_SEL_I);
                OFS_GR_D: s_d.gr[CH_D] = wr16(s_q.gr[CH_D], WB_DAT_I, WB_SEL_I);
                OFS_MASK: begin
                    if (WB_SEL_I[0]) begin
                        s_d.mask = WB_DAT_I[NCH-1:0];
                    end
                end
                default: s_d.mask = s_q.mask;
            endcase
        end
        // Capture beats a same-cycle software write to the general register
        for (int i = 0; i < NCH; i++) begin
            if (capture[i]) begin
                s_d.gr[i] = s_q.cnt;
            end
        end
    end

    // State register
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            s_q.run <= 1'b0;
            s_q.role <= '0;
            s_q.act <= {NCH{ACT_RESET}};
            s_q.cnt <= CNT_RESET;
            s_q.gr <= {NCH{GR_RESET}};
            s_q.mask <= '0;
            s_q.ack <= 1'b0;
            s_q.rdata <= 32'h0000_0000;
        end else begin
            s_q <= s_d;
        end
    end

    // Outputs; the pin is released while its channel captures
    assign WB_ACK_O = s_q.ack;
    assign WB_DAT_O = s_q.rdata;
    assign CHAN_A_PIN_O = pin_out[CH_A];
    assign CHAN_C_PIN_O = pin_out[CH_C];
    assign CHAN_D_PIN_O = pin_out[CH_D];
    assign CHAN_A_PIN_OE = s_q.role[CH_A] == ROLE_COMPARE;
    assign CHAN_C_PIN_OE = s_q.role[CH_C] == ROLE_COMPARE;
    assign CHAN_D_PIN_OE = s_q.role[CH_D] == ROLE_COMPARE;
    assign IRQ_O = irq;

    // Helper: channel A code stays at reset value until software writes it
    logic cha_written_q;
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            cha_written_q <= 1'b0;
        end else if (wr && WB_ADR_I == OFS_CHA_IO) begin
            cha_written_q <= 1'b1;
        end
    end

    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RESET_N);

    sequence s_match_a(logic [1:0] code);
        s_q.role[CH_A] == ROLE_COMPARE && s_q.act[CH_A] == code && match[CH_A];
    endsequence

    sequence s_rise_a;
        s_q.role[CH_A] == ROLE_CAPTURE && s_q.act[CH_A] == EDGE_RISE && $rose(CHAN_A_PIN_I);
    endsequence

    a_match_drive_low: assert property (s_match_a(ACT_LOW) |=> !CHAN_A_PIN_O)
        else $error("compare match did not drive channel A low");
    a_match_drive_high: assert property (s_match_a(ACT_HIGH) |=> CHAN_A_PIN_O)
        else $error("compare match did not drive channel A high");
    a_match_toggle: assert property (
        s_match_a(ACT_TOGGLE) |=> CHAN_A_PIN_O != $past(CHAN_A_PIN_O))
        else $error("compare match did not toggle channel A");
    a_match_none_hold: assert property (
        s_match_a(ACT_NONE) |=> $stable(CHAN_A_PIN_O))
        else $error("no-action match changed channel A pin");
    a_capture_rise_store: assert property (
        s_rise_a |=> s_q.gr[CH_A] == $past(s_q.cnt) && status[CH_A])
        else $error("rising edge did not capture counter into channel A");
    a_capture_fall_only: assert property (
        s_q.role[CH_C] == ROLE_CAPTURE && s_q.act[CH_C] == EDGE_FALL && $rose(CHAN_C_PIN_I)
        |-> !capture[CH_C])
        else $error("falling-edge channel captured on a rise");
    a_reset_code_zero: assert property (!cha_written_q |-> s_q.act[CH_A] == 2'h0)
        else $error("channel A action code left reset value without a write");
    a_cd_role_write: assert property (
        wr && WB_ADR_I == OFS_CD_IO && WB_SEL_I[0] && WB_DAT_I[CD_D_LSB + ROLE_BIT]
        |=> !CHAN_D_PIN_OE)
        else $error("channel D role write did not release its pin");
    a_reserved_one: assert property (
        WB_ACK_O && !WB_WE_I && $past(WB_ADR_I) == OFS_CD_IO |-> WB_DAT_O[CD_RSVD_BIT])
        else $error("reserved bit of C/D control read as 0");
    a_match_on_step: assert property (
        match[CH_A] |-> s_q.run && s_q.cnt == s_q.gr[CH_A] ##1 s_q.cnt != $past(s_q.cnt))
        else $error("compare match without a counter step");
    a_role_a_capture: assert property (s_q.role[CH_A] |-> !match[CH_A])
        else $error("channel A matched while in capture role");
    a_ack_one_cycle: assert property (WB_ACK_O |=> !WB_ACK_O)
        else $error("bus ack held for more than one cycle");
endmodule
`default_nettype wire

// ### verif/tpc_pin_model.sv
// Model of the external source on one capture/compare pin.
// Assumes the bench moves want just after a rising edge; the pin never floats.
`timescale 1ns/10ps
`default_nettype none
module tpc_pin_model (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Device side of the pin
    input wire logic oe,
    input wire logic drv_o,
    // Bench request and resolved wire
    input wire logic want,
    output logic pin
);
    logic ext_q;
    // External source launches its level from a flop, like a synchronous driver
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ext_q <= 1'b0;
        end else begin
            ext_q <= want;
        end
    end
    // The device wins while it drives, so the input sees its own output then
    assign pin = oe ? drv_o : ext_q;
endmodule
`default_nettype wire

// ### verif/tb_timer_pin_io_control.sv
// Self-checking bench for the timer pin control block.
// Assumes one ack per Wishbone request and pins synchronous to CLK.
`timescale 1ns/10ps
`default_nettype none
module tb_timer_pin_io_control;
    import tpc_pkg::*;
    logic CLK, RESET_N, we, cyc, stb, ack, irq;
    logic [7:0] adr;
    logic [31:0] wdat, rdat;
    logic [3:0] sel;
    logic [2:0] pin_i, pin_o, pin_oe, want;
    int mismatches, total_checks, cycles, seed, i;
    logic [31:0] exp_q[$], msk_q[$];
    logic [15:0] gr_exp, v;
    logic p;
    logic [6:0] obs;
    // Observed bits: enables A,C,D at 0..2, levels A,C,D at 3..5, interrupt at 6
    assign obs = {irq, pin_o, pin_oe};
    localparam logic [7:0] RST_ADR [10] = '{OFS_CTRL, OFS_CHA_IO, OFS_CD_IO, OFS_COUNT,
        OFS_GR_A, OFS_GR_C, OFS_GR_D, OFS_STATUS, OFS_MASK, 8'h30};
    localparam logic [15:0] RST_VAL [10] = '{16'h0000, 16'h0000, 16'h0080, 16'h0000,
        16'hFFFF, 16'hFFFF, 16'hFFFF, 16'h0000, 16'h0000, 16'h0000};
    localparam logic [1:0] CODES [7] = '{ACT_HIGH, ACT_NONE, ACT_LOW, ACT_TOGGLE,
        ACT_TOGGLE, ACT_HIGH, ACT_NONE};

    // Device and one external source per pin
    tpc_top tpc_top_i (.CLK(CLK), .RESET_N(RESET_N), .WB_ADR_I(adr), .WB_DAT_I(wdat),
        .WB_SEL_I(sel), .WB_WE_I(we), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_DAT_O(rdat),
        .WB_ACK_O(ack), .CHAN_A_PIN_I(pin_i[0]), .CHAN_A_PIN_O(pin_o[0]),
        .CHAN_A_PIN_OE(pin_oe[0]), .CHAN_C_PIN_I(pin_i[1]), .CHAN_C_PIN_O(pin_o[1]),
        .CHAN_C_PIN_OE(pin_oe[1]), .CHAN_D_PIN_I(pin_i[2]), .CHAN_D_PIN_O(pin_o[2]),
        .CHAN_D_PIN_OE(pin_oe[2]), .IRQ_O(irq));
    tpc_pin_model tpc_pin_model_i [2:0] (.clk(CLK), .reset_n(RESET_N), .oe(pin_oe),
        .drv_o(pin_o), .want(want), .pin(pin_i));

    // Free-running clock, 8 ns period
    initial begin
        CLK = 1'b0;
        forever #4 CLK = ~CLK;
    end

    task automatic fail(input string m);
        mismatches++;
        $display("[FAIL] %0t %s", $time, m);
    endtask

    task automatic finish_test();
        $display("Counts: %0d checks, %0d mismatches", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic chk_rd(input logic [31:0] got, input logic [31:0] e, input logic [31:0] m);
        total_checks++;
        if ((got & m) !== (e & m)) fail($sformatf("read %h expected %h", got, e));
    endtask

    // Looks half a cycle late so the edge's register updates have landed
    // The bit is picked after the wait, since an argument is frozen at the call
    task automatic chk_bit(input int k, input logic e, input string what);
        @(negedge CLK);
        total_checks++;
        if (obs[k] !== e) fail($sformatf("%s is %b expected %b", what, obs[k], e));
    endtask

    // Classic single cycle; the wait for ack gives up after 50 cycles with a failure
    task automatic wb(input logic [7:0] a, input logic [31:0] d, input logic w);
        int n;
        n = 0;
        @(posedge CLK);
        adr <= a;
        wdat <= d;
        we <= w;
        cyc <= 1'b1;
        stb <= 1'b1;
        do begin
            @(posedge CLK);
            n++;
        end while (ack !== 1'b1 && n < 50);
        if (ack !== 1'b1) fail("no ack");
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        wb(a, d, 1'b1);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
        exp_q.push_back(e);
        msk_q.push_back(m);
        wb(a, 32'h0, 1'b0);
    endtask

    // Read monitor: each answered read is matched against the oldest note
    always @(posedge CLK) begin
        if (ack === 1'b1 && cyc === 1'b1 && we === 1'b0) begin
            if (exp_q.size() == 0) fail("read with no note");
            else chk_rd(rdat, exp_q.pop_front(), msk_q.pop_front());
        end
    end

    // Hang guard, far above the few hundred cycles the run needs
    always @(posedge CLK) begin
        cycles++;
        if (cycles == 20000) begin
            fail("timeout");
            finish_test();
        end
    end

    // Main sequence
    initial begin
        seed = 52692;
        mismatches = 0;
        total_checks = 0;
        cycles = 0;
        RESET_N = 1'b0;
        adr = 8'h00;
        wdat = 32'h0;
        sel = 4'h3;
        we = 1'b0;
        cyc = 1'b0;
        stb = 1'b0;
        want = 3'h0;
        repeat (8) @(posedge CLK);
        RESET_N <= 1'b1;
        for (i = 0; i < 10; i++) rd(RST_ADR[i], {16'h0, RST_VAL[i]}, 32'hFFFFFFFF);
        chk_bit(0, 1'b1, "A enable");
        chk_bit(3, 1'b0, "A level");
        wr(OFS_CHA_IO, 32'h3);
        rd(OFS_CHA_IO, 32'h3, 32'h7);
        $display("test reset and access done");
        // Channel C/D control: reserved bit ignores writes, roles drive enables
        wr(OFS_CD_IO, 32'hFF);
        rd(OFS_CD_IO, 32'hF7, 32'hFF);
        wr(OFS_CD_IO, 32'h04);
        chk_bit(1, 1'b0, "C enable");
        chk_bit(2, 1'b1, "D enable");
        wr(OFS_CD_IO, 32'h00);
        rd(OFS_CD_IO, 32'h80, 32'hFF);
        $display("test channel C/D control done");
        // Every compare action, toggle from both starting levels
        p = 1'b0;
        for (i = 0; i < 7; i++) begin
            wr(OFS_COUNT, 32'h10);
            wr(OFS_GR_A, 32'h11);
            wr(OFS_CHA_IO, {30'h0, CODES[i]});
            wr(OFS_CTRL, 32'h1);
            repeat (6) @(posedge CLK);
            wr(OFS_CTRL, 32'h0);
            case (CODES[i])
                ACT_LOW: p = 1'b0;
                ACT_HIGH: p = 1'b1;
                ACT_TOGGLE: p = ~p;
                default: p = p;
            endcase
            chk_bit(3, p, "A compare level");
            rd(OFS_PINS, {31'h0, p}, 32'h1);
        end
        // Equal values with the counter stopped must not act
        wr(OFS_COUNT, 32'h20);
        wr(OFS_GR_A, 32'h20);
        wr(OFS_CHA_IO, {30'h0, ACT_TOGGLE});
        repeat (6) @(posedge CLK);
        chk_bit(3, p, "A held while stopped");
        wr(OFS_CTRL, 32'h1);
        wr(OFS_CTRL, 32'h0);
        chk_bit(3, ~p, "A single toggle");
        // Channels C and D toggle on their own matches, up then back down
        wr(OFS_CD_IO, 32'h33);
        wr(OFS_GR_C, 32'h31);
        wr(OFS_GR_D, 32'h31);
        for (i = 0; i < 2; i++) begin
            wr(OFS_COUNT, 32'h30);
            wr(OFS_CTRL, 32'h1);
            wr(OFS_CTRL, 32'h0);
            chk_bit(4, ~i[0], "C compare level");
            chk_bit(5, ~i[0], "D compare level");
        end
        $display("test compare done");
        // Every capture edge code, rising then falling edge
        wr(OFS_CHA_IO, {29'h0, ROLE_CAPTURE, 2'h0});
        chk_bit(0, 1'b0, "A capture enable");
        gr_exp = 16'h0020;
        for (i = 0; i < 4; i++) begin
            wr(OFS_CHA_IO, {29'h0, ROLE_CAPTURE, i[1:0]});
            rd(OFS_STATUS, (i == 0) ? 32'h7 : 32'h0, 32'h7);
            v = 16'($random(seed));
            wr(OFS_COUNT, {16'h0, v});
            want[0] <= 1'b1;
            repeat (4) @(posedge CLK);
            if (i != 1) gr_exp = v;
            rd(OFS_GR_A, {16'h0, gr_exp}, 32'hFFFF);
            v = 16'($random(seed));
            wr(OFS_COUNT, {16'h0, v});
            want[0] <= 1'b0;
            repeat (4) @(posedge CLK);
            if (i != 0) gr_exp = v;
            rd(OFS_GR_A, {16'h0, gr_exp}, 32'hFFFF);
            rd(OFS_STATUS, 32'h1, 32'h7);
        end
        // Channel C captures on a falling edge only; a rise leaves it alone
        wr(OFS_CD_IO, 32'h05);
        want[1] <= 1'b1;
        repeat (4) @(posedge CLK);
        rd(OFS_GR_C, 32'h31, 32'hFFFF);
        v = 16'($random(seed));
        wr(OFS_COUNT, {16'h0, v});
        want[1] <= 1'b0;
        repeat (4) @(posedge CLK);
        rd(OFS_GR_C, {16'h0, v}, 32'hFFFF);
        rd(OFS_STATUS, 32'h2, 32'h7);
        // Channel D capture on a rising edge
        wr(OFS_CD_IO, 32'h40);
        v = 16'($random(seed));
        wr(OFS_COUNT, {16'h0, v});
        want[2] <= 1'b1;
        repeat (4) @(posedge CLK);
        rd(OFS_GR_D, {16'h0, v}, 32'hFFFF);
        $display("test capture done");
        // Interrupt: raised while masked, unmasked, then cleared by reading
        rd(OFS_STATUS, 32'h4, 32'h7);
        wr(OFS_MASK, 32'h0);
        want[0] <= 1'b1;
        repeat (4) @(posedge CLK);
        chk_bit(6, 1'b0, "masked interrupt");
        wr(OFS_MASK, 32'h1);
        chk_bit(6, 1'b1, "interrupt");
        rd(OFS_STATUS, 32'h1, 32'h7);
        chk_bit(6, 1'b0, "interrupt after clear");
        $display("test interrupt done");
        finish_test();
    end
endmodule
`default_nettype wire
